// file: design/asm_pkg.sv
// shared constants and types for the audio slot map block
package asm_pkg;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int SLOT_W = 6;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int HALF_BIT = 5;
   localparam int HALF_IDX_W = 5;

   // -----------------------------------------------------------------
   // register indices; byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [5:0] IDX_SECOND = 6'h0c;
   localparam logic [5:0] IDX_THIRD = 6'h0d;
   localparam logic [5:0] IDX_FOURTH = 6'h0e;
   localparam logic [5:0] IDX_CONTROL = 6'h10;
   localparam logic [5:0] IDX_STATUS = 6'h11;
   localparam logic [1:0] IDX_LOW_ZERO = 2'h0;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [SLOT_W-1:0] RST_SECOND = 6'h01;
   localparam logic [SLOT_W-1:0] RST_THIRD = 6'h02;
   localparam logic [SLOT_W-1:0] RST_FOURTH = 6'h03;
   localparam logic RST_TWO_PHASE = 1'h0;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CTRL_TWO_PHASE_BIT = 0;
   localparam int STAT_SECOND_LSB = 0;
   localparam int STAT_THIRD_LSB = 6;
   localparam int STAT_FOURTH_LSB = 12;
   localparam int STAT_FORMAT_BIT = 18;

   // channel code shown with each placed word
   localparam logic [1:0] CH_NONE = 2'h0;
   localparam logic [1:0] CH_SECOND = 2'h1;
   localparam logic [1:0] CH_THIRD = 2'h2;
   localparam logic [1:0] CH_FOURTH = 2'h3;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } asm_apb_req_type;

   // current serial slot position from the frame timing logic
   typedef struct packed {
      logic strobe;
      logic half;
      logic [SLOT_W-1:0] index;
   } asm_slot_pos_type;

   // apb slave states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DONE = 3'b100
   } asm_apb_state_type;

endpackage

// file: design/asm_slot_lane.sv
// one channel lane: frame-aligned slot field and slot match
`timescale 1ns/10ps
module asm_slot_lane
   import asm_pkg::*;
#(
   parameter logic [asm_pkg::SLOT_W-1:0] RESET_FIELD = asm_pkg::RST_SECOND
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic [asm_pkg::SLOT_W-1:0] pending_field,
   input wire logic frame_start,
   input wire logic two_phase,
   input wire asm_pkg::asm_slot_pos_type slot_pos,
   // results
   output logic [asm_pkg::SLOT_W-1:0] active_field,
   output logic hit
);

   logic [SLOT_W-1:0] next_field;

   // -----------------------------------------------------------------
   // slot decode
   // -----------------------------------------------------------------
   // two-phase: bit 5 picks the half frame, low bits the slot in it
   function automatic logic slot_match(input logic [SLOT_W-1:0] field,
                                       input logic fmt_two_phase,
                                       input asm_slot_pos_type pos);
      logic m;
      m = 1'b0;
      if (fmt_two_phase) begin
         m = (pos.half == field[HALF_BIT]) &&
             (pos.index[HALF_IDX_W-1:0] == field[HALF_IDX_W-1:0]);
      end else begin
         m = (pos.index == field);
      end
      return m;
   endfunction

   // new field only at a frame boundary, usable in that same frame
   assign next_field = frame_start ? pending_field : active_field;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   // active field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_field <= RESET_FIELD;
      end else begin
         active_field <= next_field;
      end
   end

   // registered hit, one per slot strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hit <= 1'b0;
      end else begin
         hit <= slot_pos.strobe && slot_match(next_field, two_phase, slot_pos);
      end
   end

endmodule

// file: design/asm_slot_map.sv
// audio serial slot map for channels two to four with apb registers
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module asm_slot_map
   import asm_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire asm_pkg::asm_apb_req_type apb_req,
   output logic pready,
   output logic [asm_pkg::DATA_W-1:0] prdata,
   output logic pslverr,
   // frame timing
   input wire logic frame_start,
   input wire asm_pkg::asm_slot_pos_type slot_pos,
   // channel sample words
   input wire logic [asm_pkg::DATA_W-1:0] second_channel_sample,
   input wire logic [asm_pkg::DATA_W-1:0] third_channel_sample,
   input wire logic [asm_pkg::DATA_W-1:0] fourth_channel_sample,
   // placed word
   output logic slot_valid,
   output logic [asm_pkg::DATA_W-1:0] slot_data,
   output logic [1:0] slot_channel
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   asm_apb_state_type state;
   asm_apb_state_type next_state;
   logic [SLOT_W-1:0] second_channel_slot;
   logic [SLOT_W-1:0] third_channel_slot;
   logic [SLOT_W-1:0] fourth_channel_slot;
   logic [SLOT_W-1:0] active_second;
   logic [SLOT_W-1:0] active_third;
   logic [SLOT_W-1:0] active_fourth;
   logic left_justified_format;
   logic active_two_phase;
   logic next_two_phase;
   logic hit_second;
   logic hit_third;
   logic hit_fourth;
   logic do_write;
   logic take_access;
   logic [5:0] word_index;
   logic addr_mapped;
   logic [DATA_W-1:0] read_word;

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   // byte address to register index; low two bits must be zero
   function automatic logic [5:0] addr_to_index(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2];
   endfunction

   function automatic logic index_known(input logic [5:0] idx);
      return (idx == IDX_SECOND) || (idx == IDX_THIRD) || (idx == IDX_FOURTH) ||
             (idx == IDX_CONTROL) || (idx == IDX_STATUS);
   endfunction

   // slot field word with reserved bits forced to zero
   function automatic logic [DATA_W-1:0] field_word(input logic [SLOT_W-1:0] f);
      return {{(DATA_W-SLOT_W){1'b0}}, f};
   endfunction

   assign word_index = addr_to_index(apb_req.paddr);
   assign addr_mapped = index_known(word_index) && (apb_req.paddr[1:0] == IDX_LOW_ZERO);

   // -----------------------------------------------------------------
   // apb handshake
   // -----------------------------------------------------------------
   // two wait states: access seen, then pready high for one cycle
   assign take_access = apb_req.psel && apb_req.penable;
   assign do_write = (state == ST_DONE) && take_access && apb_req.pwrite && addr_mapped;

   // next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take_access) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            next_state = ST_DONE;
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // state register
   // done returns to idle whatever the bus shows, so a master that holds
   // its access past pready starts a second transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // pready and error, high in the done state only
   // two fixed wait states keep the read mux off the bus address path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= (next_state == ST_DONE);
         pslverr <= (next_state == ST_DONE) && !addr_mapped;
      end
   end

   // read mux
   // status shows the active copies, the slot registers the written ones
   always_comb begin
      read_word = '0;
      case (word_index)
         IDX_SECOND: begin
            read_word = field_word(second_channel_slot);
         end
         IDX_THIRD: begin
            read_word = field_word(third_channel_slot);
         end
         IDX_FOURTH: begin
            read_word = field_word(fourth_channel_slot);
         end
         IDX_CONTROL: begin
            read_word[CTRL_TWO_PHASE_BIT] = left_justified_format;
         end
         IDX_STATUS: begin
            read_word[STAT_SECOND_LSB +: SLOT_W] = active_second;
            read_word[STAT_THIRD_LSB +: SLOT_W] = active_third;
            read_word[STAT_FOURTH_LSB +: SLOT_W] = active_fourth;
            read_word[STAT_FORMAT_BIT] = active_two_phase;
         end
         default: begin
            read_word = '0;
         end
      endcase
      if (!addr_mapped) begin
         read_word = '0;
      end
   end

   // read data captured as pready rises, zero otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (next_state == ST_DONE && !apb_req.pwrite) begin
         prdata <= read_word;
      end else begin
         prdata <= '0;
      end
   end

   // -----------------------------------------------------------------
   // software registers
   // -----------------------------------------------------------------
   // second channel field; bits 31:6 of a write are dropped, never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_channel_slot <= RST_SECOND;
      end else if (do_write && word_index == IDX_SECOND) begin
         second_channel_slot <= apb_req.pwdata[SLOT_W-1:0];
      end
   end

   // third channel field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         third_channel_slot <= RST_THIRD;
      end else if (do_write && word_index == IDX_THIRD) begin
         third_channel_slot <= apb_req.pwdata[SLOT_W-1:0];
      end
   end

   // fourth channel field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fourth_channel_slot <= RST_FOURTH;
      end else if (do_write && word_index == IDX_FOURTH) begin
         fourth_channel_slot <= apb_req.pwdata[SLOT_W-1:0];
      end
   end

   // format select: tdm or two-phase (stereo or left-justified)
   // like the fields, it waits for the next frame start before it decodes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_justified_format <= RST_TWO_PHASE;
      end else if (do_write && word_index == IDX_CONTROL) begin
         left_justified_format <= apb_req.pwdata[CTRL_TWO_PHASE_BIT];
      end
   end

   // -----------------------------------------------------------------
   // frame-aligned format
   // -----------------------------------------------------------------
   // format switches with the fields so a frame never mixes decodes
   assign next_two_phase = frame_start ? left_justified_format : active_two_phase;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_two_phase <= RST_TWO_PHASE;
      end else begin
         active_two_phase <= next_two_phase;
      end
   end

   // -----------------------------------------------------------------
   // channel lanes
   // -----------------------------------------------------------------
   // all lanes take the format chosen for the coming slot, so a frame
   // start switches fields and decode on the same edge
   asm_slot_lane #(
      .RESET_FIELD(RST_SECOND)
   ) u_second_lane (
      .pclk(pclk),
      .presetn(presetn),
      .pending_field(second_channel_slot),
      .frame_start(frame_start),
      .two_phase(next_two_phase),
      .slot_pos(slot_pos),
      .active_field(active_second),
      .hit(hit_second)
   );

   asm_slot_lane #(
      .RESET_FIELD(RST_THIRD)
   ) u_third_lane (
      .pclk(pclk),
      .presetn(presetn),
      .pending_field(third_channel_slot),
      .frame_start(frame_start),
      .two_phase(next_two_phase),
      .slot_pos(slot_pos),
      .active_field(active_third),
      .hit(hit_third)
   );

   asm_slot_lane #(
      .RESET_FIELD(RST_FOURTH)
   ) u_fourth_lane (
      .pclk(pclk),
      .presetn(presetn),
      .pending_field(fourth_channel_slot),
      .frame_start(frame_start),
      .two_phase(next_two_phase),
      .slot_pos(slot_pos),
      .active_field(active_fourth),
      .hit(hit_fourth)
   );

   // -----------------------------------------------------------------
   // slot output
   // -----------------------------------------------------------------
   // shared slot: lowest channel wins, others are dropped for that slot
   // a collision costs the lower-priority channels their words for the
   // whole frame; software must keep the three fields apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_valid <= 1'b0;
         slot_data <= '0;
         slot_channel <= CH_NONE;
      end else begin
         slot_valid <= hit_second || hit_third || hit_fourth;
         if (hit_second) begin
            slot_data <= second_channel_sample;
            slot_channel <= CH_SECOND;
         end else if (hit_third) begin
            slot_data <= third_channel_sample;
            slot_channel <= CH_THIRD;
         end else if (hit_fourth) begin
            slot_data <= fourth_channel_sample;
            slot_channel <= CH_FOURTH;
         end else begin
            slot_data <= '0;
            slot_channel <= CH_NONE;
         end
      end
   end

endmodule

// file: tb/asm_frame_host.sv
// host-side frame timing and sample source facing the slot map
`timescale 1ns/10ps
module asm_frame_host
   import asm_pkg::*;
(
   // clock
   input wire logic pclk,
   // frame timing
   output logic frame_start,
   output asm_pkg::asm_slot_pos_type slot_pos,
   // sample words
   output logic [asm_pkg::DATA_W-1:0] second_channel_sample,
   output logic [asm_pkg::DATA_W-1:0] third_channel_sample,
   output logic [asm_pkg::DATA_W-1:0] fourth_channel_sample
);
   logic [23:0] tick;
   initial begin
      frame_start = 1'b0;
      slot_pos = '0;
      tick = 24'h0;
   end
   // words change each cycle so a read one cycle off shows
   always @(posedge pclk) begin
      tick <= tick + 24'h1;
   end
   assign second_channel_sample = {8'h02, tick};
   assign third_channel_sample = {8'h03, ~tick};
   assign fourth_channel_sample = {8'h04, tick ^ 24'h5a5a5a};
   // 64 strobes, gap idle cycles after each; each idle cycle inverts the position before it
   task automatic run_frame(input logic tp, input int gap);
      for (int k = 0; k < 64; k++) begin
         @(posedge pclk);
         frame_start <= (k == 0);
         slot_pos <= '{1'b1, k[5], tp ? {~k[5], k[4:0]} : 6'(k)};
         repeat (gap) begin
            @(posedge pclk);
            frame_start <= 1'b0;
            slot_pos <= '{1'b0, ~slot_pos.half, ~slot_pos.index};
         end
      end
      @(posedge pclk);
      frame_start <= 1'b0;
      slot_pos.strobe <= 1'b0;
   endtask
endmodule

// file: tb/asm_slot_map_sva.sv
// port-level checks of the audio slot map
`timescale 1ns/10ps
module asm_slot_map_sva
   import asm_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire asm_pkg::asm_apb_req_type apb_req,
   input wire logic pready,
   input wire logic [asm_pkg::DATA_W-1:0] prdata,
   input wire logic pslverr,
   // slot path
   input wire logic frame_start,
   input wire asm_pkg::asm_slot_pos_type slot_pos,
   input wire logic [asm_pkg::DATA_W-1:0] second_channel_sample,
   input wire logic [asm_pkg::DATA_W-1:0] third_channel_sample,
   input wire logic [asm_pkg::DATA_W-1:0] fourth_channel_sample,
   input wire logic slot_valid,
   input wire logic [asm_pkg::DATA_W-1:0] slot_data,
   input wire logic [1:0] slot_channel
);
   // single domain, so clock and reset are given once
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic slot_reg;
   assign slot_reg = apb_req.paddr inside {8'h30, 8'h34, 8'h38};

   AST_ANSWER_LAT: assert property ($rose(apb_req.psel && apb_req.penable) |->
      !pready ##[1:2] pready) else $error("pready late");
   AST_ANSWER_PULSE: assert property (pready |=> !pready) else $error("pready held");
   AST_IDLE_BUS: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("bus outputs outside answer");
   AST_RESV_ZERO: assert property (
      pready && !apb_req.pwrite && slot_reg |-> prdata[31:6] == 26'h0)
      else $error("reserved bits nonzero");
   AST_MISALIGN: assert property (pready && apb_req.paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned not refused");
   AST_MAPPED_OK: assert property (pready && slot_reg |-> !pslverr) else $error("mapped refused");
   AST_VALID_CAUSE: assert property (slot_valid |-> $past(slot_pos.strobe, 2))
      else $error("word without strobe");
   AST_NO_STROBE: assert property (!slot_pos.strobe |-> ##2 !slot_valid)
      else $error("word after idle slot");
   AST_SLOT_WORD: assert property (
      slot_valid |-> slot_channel != CH_NONE && slot_data == (slot_channel == CH_SECOND ?
      $past(second_channel_sample) : slot_channel == CH_THIRD ?
      $past(third_channel_sample) : $past(fourth_channel_sample)))
      else $error("wrong word placed");
   AST_EMPTY_SLOT: assert property (!slot_valid |-> slot_data == 32'h0 && slot_channel == CH_NONE)
      else $error("empty slot not zero");
endmodule

bind asm_slot_map asm_slot_map_sva chk_i (.pclk, .presetn, .apb_req, .pready, .prdata, .pslverr,
   .frame_start, .slot_pos, .second_channel_sample, .third_channel_sample,
   .fourth_channel_sample, .slot_valid, .slot_data, .slot_channel);

// file: tb/asm_slot_map_tb_top.sv
// self-checking bench for the audio slot map
`timescale 1ns/10ps
module asm_slot_map_tb_top;
   import asm_pkg::*;
   logic pclk;
   logic presetn;
   asm_apb_req_type apb_req;
   logic pready;
   logic pslverr;
   logic [DATA_W-1:0] prdata;
   logic frame_start;
   asm_slot_pos_type slot_pos;
   logic [DATA_W-1:0] smp2;
   logic [DATA_W-1:0] smp3;
   logic [DATA_W-1:0] smp4;
   logic slot_valid;
   logic [DATA_W-1:0] slot_data;
   logic [1:0] slot_channel;
   int error_cnt = 0;
   int total_checks = 0;
   logic [SLOT_W-1:0] act [3];
   logic act_fmt;
   logic [1:0] got [64];
   asm_slot_pos_type pos_d1;
   asm_slot_pos_type pos_d2;

   asm_slot_map uut (.pclk, .presetn, .apb_req, .pready, .prdata, .pslverr, .frame_start,
      .slot_pos, .second_channel_sample(smp2), .third_channel_sample(smp3),
      .fourth_channel_sample(smp4), .slot_valid, .slot_data, .slot_channel);
   asm_frame_host host (.pclk, .frame_start, .slot_pos, .second_channel_sample(smp2),
      .third_channel_sample(smp3), .fourth_channel_sample(smp4));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // owner of each slot, taken two edges after its strobe
   always @(posedge pclk) begin
      pos_d1 <= slot_pos;
      pos_d2 <= pos_d1;
      if (pos_d2.strobe === 1'b1)
         got[act_fmt ? {pos_d2.half, pos_d2.index[4:0]} : pos_d2.index] <= slot_channel;
   end

   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   // one transfer; pready is sampled at the rising edge, request held until then
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
         output logic [DATA_W-1:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd = prdata;
      err = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk(32'h0, 32'h1, "apb timeout");
         end_of_test();
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input logic xe);
      logic [DATA_W-1:0] r;
      logic e;
      xfer(1'b0, a, 32'h0, r, e);
      chk(r, x, "read data");
      chk({31'h0, e}, {31'h0, xe}, "slave error");
   endtask
   function automatic logic [DATA_W-1:0] exp_status();
      return {13'h0, act_fmt, act[2], act[1], act[0]};
   endfunction
   // lowest channel wins a shared slot; two-phase code bit 5 is the half
   function automatic logic [1:0] exp_ch(input int k);
      for (int c = 0; c < 3; c++)
         if (act[c] == k[5:0])
            return 2'(c + 1);
      return CH_NONE;
   endfunction
   task automatic reset_check();
      act = '{RST_SECOND, RST_THIRD, RST_FOURTH};
      act_fmt = 1'b0;
      rd(8'h30, 32'h1, 1'b0);
      rd(8'h34, 32'h2, 1'b0);
      rd(8'h38, 32'h3, 1'b0);
      rd(8'h40, 32'h0, 1'b0);
      rd(8'h44, exp_status(), 1'b0);
   endtask
   // program a map, see it wait for the frame, then check every slot
   task automatic map_case(input logic [SLOT_W-1:0] f [3], input logic tp, input int gap);
      for (int i = 0; i < 3; i++)
         wr(8'(8'h30 + 4 * i), {26'h0, f[i]});
      wr(8'h40, {31'h0, tp});
      for (int i = 0; i < 3; i++)
         rd(8'(8'h30 + 4 * i), {26'h0, f[i]}, 1'b0);
      rd(8'h40, {31'h0, tp}, 1'b0);
      rd(8'h44, exp_status(), 1'b0);
      act = f;
      act_fmt = tp;
      host.run_frame(tp, gap);
      repeat (3) @(posedge pclk);
      for (int k = 0; k < 64; k++)
         chk({30'h0, got[k]}, {30'h0, exp_ch(k)}, "slot owner");
      rd(8'h44, exp_status(), 1'b0);
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // cut a hang short
   initial begin
      repeat (30000) @(posedge pclk);
      error_cnt++;
      end_of_test();
   end
   // main sequence: corners first, then random maps, then a second reset
   initial begin
      logic [SLOT_W-1:0] f [3];
      apb_req = '0;
      presetn = 1'b0;
      act_fmt = 1'b0;
      void'($urandom(47960));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      reset_check();
      rd(8'h48, 32'h0, 1'b1);
      rd(8'h31, 32'h0, 1'b1);
      wr(8'h44, 32'hffffffff);
      rd(8'h44, exp_status(), 1'b0);
      map_case(act, 1'b0, 0);
      f = '{6'h00, 6'h3f, 6'h20};
      map_case(f, 1'b1, 1);
      f = '{6'h1f, 6'h20, 6'h3f};
      map_case(f, 1'b0, 0);
      f = '{6'h21, 6'h21, 6'h21};
      map_case(f, 1'b1, 0);
      for (int i = 0; i < 6; i++) begin
         foreach (f[j])
            f[j] = 6'($urandom_range(63));
         map_case(f, 1'($urandom_range(1)), int'($urandom_range(2)));
      end
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      reset_check();
      end_of_test();
   end
endmodule
